// ==== hdl/lpm_release_ctrl.sv ====
// Low-power mode controller: deep-sleep entry, release and warm-up, CPU-halt entry and release.
// What this block does
// R1: Sleep bit write stops both oscillators.
// R2: Key-wakeup at selected level releases deep sleep.
// R3: Key level reversal after warm-up start ignored.
// R4: Supply drop with detector reset releases, asserts reset.
// R5: Supply recovery releases reset, warm-up, single-clock run.
// R6: Supply recovery within one machine cycle ignored.
// R7: Release restarts oscillation, then counted halted warm-up.
// R8: Warm-up end resumes, clears prescaler and divider.
// R9: From single-clock run restart fast oscillator only.
// R10: From dual-clock run restart both oscillators.
// R11: From low-frequency run restart slow oscillator only.
// R12: Dual-clock return feeds fast clock to warm-up divider.
// R13: Halt stops CPU and watchdog, peripherals run.
// R14: Halt retains memory, registers, status, port latches.
// R15: Halted program counter points two instructions ahead.
// R16: Software clears master enable, sets wake enables first.
// R17: Halt bit write enters CPU-halt mode.
// R18: Pending release at entry keeps halt bit clear.
// R19: Watchdog interrupt just before entry blocks halt.
// R20: Halt release clears halt bit, restores mode.
// R21: Any reset releases halt, warms up, single-clock.
// R22: Master off: enabled latch wakes without service.
// R23: Master on: enabled latch wakes and is serviced.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module lpm_release_ctrl
    import lpm_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter int WU_DIV = 64
) (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RST,
    // Register port.
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Pins from outside the clock domain.
    input wire logic KEY_WAKE,
    input wire logic VDET_LOW,
    input wire logic EXT_RESET,
    // Interrupt state from the CPU core.
    input wire logic MASTER_IRQ_ENABLE,
    input wire logic [NUM_IRQ-1:0] IRQ_PENDING_LATCH,
    input wire logic [NUM_IRQ-1:0] PER_SOURCE_IRQ_ENABLE,
    input wire logic WDT_IRQ,
    // Clock and core control.
    output logic FAST_OSC_EN,
    output logic SLOW_OSC_EN,
    output logic WARMUP_SRC_FAST,
    output logic CPU_HALT,
    output logic WDT_HALT,
    output logic PERIPH_HALT,
    output logic SYS_RESET,
    output logic PRESCALER_CLEAR,
    output logic RESUME,
    output logic SERVICE_IRQ
);
    import lpm_pkg::*;

    localparam int DIVW = $clog2(WU_DIV + 1);
    localparam logic [DIVW-1:0] DIV_LAST = DIVW'(WU_DIV - 1);
    localparam logic [DIVW-1:0] DIV_ZERO = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic key_meta_r, key_r, vdet_meta_r, vdet_r, xrst_meta_r, xrst_r;

    // Two stages per pin; only the second stage feeds any logic.
    always_ff @(posedge CORE_CLK) begin
        key_meta_r <= KEY_WAKE;
        key_r <= key_meta_r;
        vdet_meta_r <= VDET_LOW;
        vdet_r <= vdet_meta_r;
        xrst_meta_r <= EXT_RESET;
        xrst_r <= xrst_meta_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    logic [7:0] sc1_r, sc2_r, warmup_r;
    lpm_state_e state_r;
    run_mode_e prior_mode_r;
    logic [7:0] wu_cnt_r;
    logic [DIVW-1:0] div_r;
    logic [7:0] guard_r;
    logic wu_src_fast_r;

    logic wr_sc1, wr_sc2, sleep_req, halt_req, wake_latch, halt_refused;
    logic key_release, vdet_rst_req, reset_req, wu_tick, wu_done;
    run_mode_e cur_mode;

    assign wr_sc1 = WR && (ADDR == ADDR_SYSCTL_ONE);
    assign wr_sc2 = WR && (ADDR == ADDR_SYSCTL_TWO);
    assign sleep_req = wr_sc1 && WDATA[SC1_SLEEP_BIT] && (state_r == ST_RUN); // R1
    assign halt_req = wr_sc2 && WDATA[SC2_HALT_BIT] && (state_r == ST_RUN); // R17
    // A wake source already pending, or a watchdog interrupt, keeps the core running.
    assign wake_latch = |(IRQ_PENDING_LATCH & PER_SOURCE_IRQ_ENABLE); // R22 R23
    assign halt_refused = wake_latch || WDT_IRQ; // R18 R19
    // Key-wakeup matches the configured release level, high or low.
    assign key_release = (key_r == sc1_r[SC1_KEY_LEVEL_BIT]); // R2
    assign vdet_rst_req = sc1_r[SC1_VDET_RST_BIT] && vdet_r; // R4
    assign reset_req = xrst_r || vdet_rst_req; // R21
    assign wu_tick = (div_r == DIV_LAST);
    assign wu_done = wu_tick && (wu_cnt_r == ZERO8);

    // Current run mode derived from the clock settings of the second control register.
    always_comb begin
        if (sc2_r[SC2_SYSCK_BIT]) begin
            cur_mode = MODE_LOW_FREQ;
        end else if (sc2_r[SC2_XTEN_BIT]) begin
            cur_mode = MODE_DUAL_FAST;
        end else begin
            cur_mode = MODE_SINGLE_FAST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode sequencer.

    // Resets win over every other event, except in sleep inside the guard window, so a halted or sleeping core always comes back.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_r <= ST_RESET_HOLD;
        end else if (reset_req && (state_r != ST_SLEEP || guard_r == ZERO8)) begin
            state_r <= ST_RESET_HOLD; // R4 R21
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (sleep_req) begin
                        state_r <= ST_SLEEP; // R1
                    end else if (halt_req && !halt_refused) begin
                        state_r <= ST_HALT; // R17
                    end
                end
                ST_HALT: begin
                    if (wake_latch) begin
                        state_r <= ST_RUN; // R20
                    end
                end
                ST_SLEEP: begin
                    if (key_release) begin
                        state_r <= ST_WARMUP; // R2 R7
                    end
                end
                ST_RESET_HOLD: begin
                    state_r <= ST_WARMUP; // R5
                end
                ST_WARMUP: begin
                    // Key level is no longer looked at here, so sleep is never re-entered.
                    if (wu_done) begin
                        state_r <= ST_RUN; // R3 R8
                    end
                end
                default: begin
                    state_r <= ST_RESET_HOLD;
                end
            endcase
        end
    end

    // Guard window of one machine cycle after sleep entry: the sequencer ignores supply events inside it, though SYS_RESET still follows them.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            guard_r <= ZERO8;
        end else if (sleep_req) begin
            guard_r <= MC_CYCLES; // R6
        end else if (guard_r != ZERO8) begin
            guard_r <= guard_r - ONE8;
        end
    end

    // Remember the run mode in effect when deep sleep began; a reset forces single-clock run.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            prior_mode_r <= MODE_SINGLE_FAST;
        end else if (state_r == ST_RESET_HOLD) begin
            prior_mode_r <= MODE_SINGLE_FAST; // R5 R21
        end else if (sleep_req) begin
            prior_mode_r <= cur_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Warm-up divider and counter.

    // The divider stands for the oscillator-fed prescaler; it is held clear outside warm-up.
    always_ff @(posedge CORE_CLK) begin
        if (RST || state_r != ST_WARMUP) begin
            div_r <= DIV_ZERO;
        end else if (wu_tick) begin
            div_r <= DIV_ZERO;
        end else begin
            div_r <= div_r + DIVW'(1);
        end
    end

    // Count loads on entry to warm-up and runs down on each divided tick.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wu_cnt_r <= WARMUP_RESET;
        end else if (state_r != ST_WARMUP) begin
            wu_cnt_r <= warmup_r; // R7
        end else if (wu_tick && wu_cnt_r != ZERO8) begin
            wu_cnt_r <= wu_cnt_r - ONE8;
        end
    end

    // Divider source: the fast clock unless the prior mode ran on the slow clock alone.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wu_src_fast_r <= 1'b1;
        end else if (state_r != ST_WARMUP) begin
            wu_src_fast_r <= (prior_mode_r != MODE_LOW_FREQ); // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers.

    // First control register: the sleep bit self-clears when the core resumes.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sc1_r <= SC1_RESET;
        end else if (state_r == ST_WARMUP && wu_done) begin
            sc1_r[SC1_SLEEP_BIT] <= 1'b0;
        end else if (wr_sc1 && state_r == ST_RUN) begin
            sc1_r <= WDATA; // R1
        end
    end

    // Second control register: the halt bit is set only on a taken entry and clears on release.
    always_ff @(posedge CORE_CLK) begin
        if (RST || state_r == ST_RESET_HOLD) begin
            sc2_r <= SC2_RESET; // R21
        end else if (state_r == ST_HALT && wake_latch) begin
            sc2_r[SC2_HALT_BIT] <= 1'b0; // R20
        end else if (wr_sc2 && state_r == ST_RUN) begin
            sc2_r <= WDATA;
            sc2_r[SC2_HALT_BIT] <= WDATA[SC2_HALT_BIT] && !halt_refused && !sleep_req; // R18 R19
        end
    end

    // Warm-up length, in divided ticks.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            warmup_r <= WARMUP_RESET;
        end else if (WR && ADDR == ADDR_WARMUP) begin
            warmup_r <= WDATA;
        end
    end

    // Read data appear in the cycle after the strobe and only there.
    always_ff @(posedge CORE_CLK) begin
        if (RST || !RD) begin
            RDATA <= ZERO8;
        end else if (ADDR == ADDR_SYSCTL_ONE) begin
            RDATA <= sc1_r;
        end else if (ADDR == ADDR_SYSCTL_TWO) begin
            RDATA <= sc2_r;
        end else if (ADDR == ADDR_WARMUP) begin
            RDATA <= warmup_r;
        end else begin
            RDATA <= {FAST_OSC_EN, SLOW_OSC_EN, WARMUP_SRC_FAST, 2'(prior_mode_r), 3'(state_r)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator enables.

    // Sleep and reset hold stop both; warm-up restarts what the prior mode used; run follows the register.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            FAST_OSC_EN <= 1'b0;
            SLOW_OSC_EN <= 1'b0;
        end else if (state_r == ST_SLEEP || state_r == ST_RESET_HOLD || sleep_req) begin
            FAST_OSC_EN <= 1'b0; // R1
            SLOW_OSC_EN <= 1'b0;
        end else if (state_r == ST_WARMUP) begin
            FAST_OSC_EN <= (prior_mode_r != MODE_LOW_FREQ); // R9 R10 R11
            SLOW_OSC_EN <= (prior_mode_r != MODE_SINGLE_FAST); // R9 R10 R11
        end else begin
            FAST_OSC_EN <= sc2_r[SC2_XEN_BIT];
            SLOW_OSC_EN <= sc2_r[SC2_XTEN_BIT] || sc2_r[SC2_SYSCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core control outputs.

    // CPU and watchdog stop in halt and in every sleep phase; peripherals stop in every state but run and halt.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            CPU_HALT <= 1'b1;
            WDT_HALT <= 1'b1;
            PERIPH_HALT <= 1'b1;
            SYS_RESET <= 1'b1;
            WARMUP_SRC_FAST <= 1'b1;
        end else begin
            // The core freezes its pc two ahead and keeps its state while this is high.
            CPU_HALT <= (state_r != ST_RUN); // R13 R14 R15
            WDT_HALT <= (state_r != ST_RUN); // R13
            PERIPH_HALT <= (state_r != ST_RUN) && (state_r != ST_HALT); // R7 R13
            SYS_RESET <= (state_r == ST_RESET_HOLD) || reset_req; // R4 R5
            WARMUP_SRC_FAST <= wu_src_fast_r; // R12
        end
    end

    // One-cycle pulses marking a resume, and whether the waking interrupt is to be serviced.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PRESCALER_CLEAR <= 1'b0;
            RESUME <= 1'b0;
            SERVICE_IRQ <= 1'b0;
        end else begin
            PRESCALER_CLEAR <= (state_r == ST_WARMUP) && wu_done; // R8
            RESUME <= ((state_r == ST_WARMUP) && wu_done) || ((state_r == ST_HALT) && wake_latch && !reset_req);
            SERVICE_IRQ <= (state_r == ST_HALT) && wake_latch && !reset_req && MASTER_IRQ_ENABLE; // R22 R23
        end
    end
endmodule : lpm_release_ctrl

// ==== hdl/lpm_pkg.sv ====
// Constants for the low-power mode release controller.
package lpm_pkg;
    // Register indices on the plain register port.
    localparam logic [1:0] ADDR_SYSCTL_ONE = 2'h0;
    localparam logic [1:0] ADDR_SYSCTL_TWO = 2'h1;
    localparam logic [1:0] ADDR_WARMUP = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;
    // system_control_one fields.
    localparam int SC1_SLEEP_BIT = 7;
    localparam int SC1_VDET_RST_BIT = 1;
    localparam int SC1_KEY_LEVEL_BIT = 0;
    // system_control_two fields.
    localparam int SC2_XEN_BIT = 7;
    localparam int SC2_XTEN_BIT = 6;
    localparam int SC2_SYSCK_BIT = 5;
    localparam int SC2_HALT_BIT = 4;
    // Reset values: single-clock fast run, every request clear.
    localparam logic [7:0] SC1_RESET = 8'h00;
    localparam logic [7:0] SC2_RESET = 8'h80;
    localparam logic [7:0] WARMUP_RESET = 8'hFF;
    // Status register fields.
    localparam int ST_HF_BIT = 7;
    localparam int ST_LF_BIT = 6;
    localparam int ST_SRC_BIT = 5;
    localparam int ST_MODE_LSB = 3;
    localparam int ST_STATE_LSB = 0;
    // Clock and machine cycle timing.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MACHINE_CYCLE_PS = 20000;
    localparam int MC_CYCLES_INT = (MACHINE_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] MC_CYCLES = MC_CYCLES_INT[7:0];
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] ONE8 = 8'h01;
    // Run modes that may precede a deep sleep.
    typedef enum logic [1:0] {
        MODE_SINGLE_FAST,
        MODE_DUAL_FAST,
        MODE_LOW_FREQ
    } run_mode_e;
    // Controller states.
    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT,
        ST_SLEEP,
        ST_RESET_HOLD,
        ST_WARMUP
    } lpm_state_e;
endpackage : lpm_pkg

// ==== verif/lpm_release_ctrl_monitor.sv ====
// Port-level assertion checker for the low-power mode release controller.
`timescale 1ns/1ps
module lpm_release_ctrl_checker
    import lpm_pkg::*;
#(
    parameter int NUM_IRQ = 8
) (
    // Clock, reset and register writes.
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    // Far-side inputs.
    input wire logic VDET_LOW,
    input wire logic MASTER_IRQ_ENABLE,
    input wire logic [NUM_IRQ-1:0] IRQ_PENDING_LATCH,
    input wire logic [NUM_IRQ-1:0] PER_SOURCE_IRQ_ENABLE,
    input wire logic WDT_IRQ,
    // Controller outputs.
    input wire logic FAST_OSC_EN,
    input wire logic SLOW_OSC_EN,
    input wire logic CPU_HALT,
    input wire logic WDT_HALT,
    input wire logic PERIPH_HALT,
    input wire logic SYS_RESET,
    input wire logic PRESCALER_CLEAR,
    input wire logic RESUME,
    input wire logic SERVICE_IRQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic det_en_r;
    logic wake;
    ////////////////////////////////////////
    // Shadow of the detector-reset enable; writes only land while the core runs.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            det_en_r <= 1'b0;
        end else if (WR && ADDR == ADDR_SYSCTL_ONE && !CPU_HALT) begin
            det_en_r <= WDATA[SC1_VDET_RST_BIT];
        end
    end
    assign wake = |(IRQ_PENDING_LATCH & PER_SOURCE_IRQ_ENABLE);
    sequence halt_wr_s;
        WR && ADDR == ADDR_SYSCTL_TWO && WDATA[SC2_HALT_BIT] && !CPU_HALT && !VDET_LOW;
    endsequence
    sequence halted_s;
        CPU_HALT && !PERIPH_HALT;
    endsequence
    AST_SLEEP_OFF: assert property (WR && ADDR == ADDR_SYSCTL_ONE && WDATA[SC1_SLEEP_BIT] && !CPU_HALT
        |=> ##1 !FAST_OSC_EN && !SLOW_OSC_EN && PERIPH_HALT) else $error("oscillators still on in sleep");
    AST_HALT_IN: assert property (halt_wr_s ##0 (!wake && !WDT_IRQ) |=> ##[1:2] CPU_HALT)
        else $error("halt request not taken");
    AST_HALT_REFUSE: assert property (halt_wr_s ##0 (wake || WDT_IRQ) |=> !CPU_HALT [*3])
        else $error("halt entered with release pending");
    // The halt flag lags the release by a cycle, so only the first cycle of a wake, before the pulse, is looked at.
    AST_HALT_WAKE: assert property (halted_s ##0 (wake && !RESUME) |-> ##[1:3] RESUME)
        else $error("enabled latch did not end halt");
    AST_SERVICE: assert property (RESUME && !PRESCALER_CLEAR |-> SERVICE_IRQ == $past(MASTER_IRQ_ENABLE))
        else $error("service flag does not follow master enable");
    AST_WARM_END: assert property (PRESCALER_CLEAR |-> RESUME && !SERVICE_IRQ ##1 !PRESCALER_CLEAR)
        else $error("warm-up end pulse malformed");
    AST_WDT_STOP: assert property (halted_s |-> WDT_HALT)
        else $error("watchdog runs during halt");
    AST_DET_RESET: assert property ((det_en_r && VDET_LOW) [*8] |-> SYS_RESET)
        else $error("low supply gave no reset");
    AST_RESET_WARM: assert property ($fell(SYS_RESET) |-> PERIPH_HALT && CPU_HALT)
        else $error("no warm-up after reset");
endmodule : lpm_release_ctrl_checker

// ==== verif/lpm_irq_core_model.sv ====
// Behavioural core interrupt side: pending latches set on request, cleared on resume.
`timescale 1ns/1ps
module lpm_irq_core_model #(
    parameter int NUM_IRQ = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Requests from the bench.
    input wire logic [NUM_IRQ-1:0] raise,
    input wire logic clear,
    // Controller side.
    input wire logic resume,
    output logic [NUM_IRQ-1:0] latch
);
    // The core clears the waking latch once it resumes, as the wake routine would.
    always_ff @(posedge clk) begin
        if (rst) begin
            latch <= '0;
        end else if (resume || clear) begin
            latch <= raise;
        end else begin
            latch <= latch | raise;
        end
    end
endmodule : lpm_irq_core_model

// ==== verif/lpm_release_ctrl_tb.sv ====
// Self-checking testbench for the low-power mode release controller.
`timescale 1ns/1ps
module lpm_release_ctrl_tb;
    import lpm_pkg::*;
    localparam int NUM_IRQ = 8;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, key = 1'b0, vdet = 1'b0, ext = 1'b0, mie = 1'b0;
    logic wdt = 1'b0, clr = 1'b0, fast, slow, src, chalt, whalt, phalt, sreset, pclr, resume, service;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, en = 8'h00, raise = 8'h00, latch;
    logic [7:0] sc2v [3] = '{8'h80, 8'hC0, 8'h60};
    logic [7:0] wexp [3] = '{8'hA4, 8'hEC, 8'h54};
    int fail_count = 0, n_tests = 0, cyc = 0;
    // Warm-up divider cut to 2 so that every warm-up stays short.
    lpm_release_ctrl #(.NUM_IRQ(NUM_IRQ), .WU_DIV(2)) dut (.CORE_CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .KEY_WAKE(key), .VDET_LOW(vdet), .EXT_RESET(ext),
        .MASTER_IRQ_ENABLE(mie), .IRQ_PENDING_LATCH(latch), .PER_SOURCE_IRQ_ENABLE(en), .WDT_IRQ(wdt),
        .FAST_OSC_EN(fast), .SLOW_OSC_EN(slow), .WARMUP_SRC_FAST(src), .CPU_HALT(chalt), .WDT_HALT(whalt),
        .PERIPH_HALT(phalt), .SYS_RESET(sreset), .PRESCALER_CLEAR(pclr), .RESUME(resume), .SERVICE_IRQ(service));
    lpm_irq_core_model #(.NUM_IRQ(NUM_IRQ)) u_core (.clk(clk), .rst(rst), .raise(raise), .clear(clr),
        .resume(resume), .latch(latch));
    ////////////////////////////////////////
    // Clock and a cycle ceiling well above the few warm-ups the run needs.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Waits on the falling edge for resume (sel 0) or system reset (sel 1), bounded.
    task automatic wait_for(input int sel, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((sel == 0 && resume === 1'b1) || (sel == 1 && sreset === 1'b1)) break;
        end
        chk({7'h00, i < lim}, 8'h01);
    endtask : wait_for
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic lvl;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_for(0, 2000);
        rd_reg(ADDR_SYSCTL_TWO, d); chk(d, SC2_RESET);
        wr_reg(ADDR_WARMUP, 8'h07);
        $display("test reset done");
        @(posedge clk);
        en <= 8'h01;
        raise <= 8'h01;
        @(posedge clk);
        raise <= 8'h00;
        wr_reg(ADDR_SYSCTL_TWO, 8'h90); rd_reg(ADDR_SYSCTL_TWO, d); chk(d, 8'h80);
        clr <= 1'b1;
        wdt <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr_reg(ADDR_SYSCTL_TWO, 8'h90); rd_reg(ADDR_SYSCTL_TWO, d); chk(d, 8'h80);
        wdt <= 1'b0;
        $display("test halt refusal done");
        for (int m = 0; m < 2; m++) begin
            mie <= m[0];
            wr_reg(ADDR_SYSCTL_TWO, 8'h90);
            repeat (3) @(negedge clk);
            chk({5'h00, chalt, whalt, phalt}, 8'h06);
            @(posedge clk);
            raise <= 8'h01;
            @(posedge clk);
            raise <= 8'h00;
            wait_for(0, 20); chk({7'h00, service}, {7'h00, m[0]});
            rd_reg(ADDR_SYSCTL_TWO, d); chk(d, 8'h80);
        end
        mie <= 1'b0;
        $display("test halt wake done");
        for (int m = 0; m < 3; m++) begin
            lvl = m[0];
            @(posedge clk);
            key <= ~lvl;
            wr_reg(ADDR_SYSCTL_TWO, sc2v[m]);
            wr_reg(ADDR_SYSCTL_ONE, {7'h40, lvl});
            repeat (2) @(posedge clk);
            rd_reg(ADDR_STATUS, d); chk(d, {2'h0, m != 2, m[1:0], 3'h2});
            @(posedge clk);
            key <= lvl;
            repeat (8) @(posedge clk);
            rd_reg(ADDR_STATUS, d); chk(d, wexp[m]);
            @(posedge clk);
            key <= ~lvl;
            wait_for(0, 40); chk({7'h00, pclr}, 8'h01);
            rd_reg(ADDR_SYSCTL_ONE, d); chk(d, {7'h00, lvl});
        end
        wr_reg(ADDR_SYSCTL_TWO, 8'h80);
        $display("test sleep release done");
        wr_reg(ADDR_SYSCTL_ONE, 8'h02);
        @(posedge clk);
        addr <= ADDR_SYSCTL_ONE;
        wdata <= 8'h82;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        vdet <= 1'b1;
        @(posedge clk);
        vdet <= 1'b0;
        repeat (8) @(posedge clk);
        rd_reg(ADDR_STATUS, d); chk(d & 8'h07, 8'h02);
        @(posedge clk);
        vdet <= 1'b1;
        wait_for(1, 20);
        // Hold the low supply long enough for the checker's detector-reset property to see it.
        repeat (8) @(posedge clk);
        vdet <= 1'b0;
        wait_for(0, 2000);
        rd_reg(ADDR_SYSCTL_TWO, d); chk(d, 8'h80);
        rd_reg(ADDR_STATUS, d); chk(d & 8'h1F, 8'h00);
        $display("test detector done");
        wr_reg(ADDR_SYSCTL_TWO, 8'h90);
        repeat (3) @(posedge clk);
        ext <= 1'b1;
        wait_for(1, 20);
        @(posedge clk);
        ext <= 1'b0;
        wait_for(0, 2000);
        rd_reg(ADDR_SYSCTL_TWO, d); chk(d, 8'h80);
        $display("test external reset done");
        end_sim();
    end
endmodule : lpm_release_ctrl_tb
bind lpm_release_ctrl lpm_release_ctrl_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .VDET_LOW(VDET_LOW), .MASTER_IRQ_ENABLE(MASTER_IRQ_ENABLE),
    .IRQ_PENDING_LATCH(IRQ_PENDING_LATCH), .PER_SOURCE_IRQ_ENABLE(PER_SOURCE_IRQ_ENABLE), .WDT_IRQ(WDT_IRQ),
    .FAST_OSC_EN(FAST_OSC_EN), .SLOW_OSC_EN(SLOW_OSC_EN), .CPU_HALT(CPU_HALT), .WDT_HALT(WDT_HALT),
    .PERIPH_HALT(PERIPH_HALT), .SYS_RESET(SYS_RESET), .PRESCALER_CLEAR(PRESCALER_CLEAR), .RESUME(RESUME),
    .SERVICE_IRQ(SERVICE_IRQ));
